// ===== dws_pkg.sv
package dws_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int PIN_DRIVE_NS    = 1000;
	localparam int PIN_DRIVE_CYC   = (PIN_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_SETTLE_NS   = 200;
	localparam int PIN_SETTLE_CYC  = (PIN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DET_CNT_W       = 8;
	localparam int FILTER_TAPS     = 3;

	// Serial word layout
	localparam int          RESOLUTION  = 16;
	localparam logic [6:0]  GLOBAL_ADDR = 7'h73;
	localparam logic [2:0]  ADDR_HI_INC = 3'h1;
	localparam logic [3:0]  BIT_LAST    = 4'h8;
	localparam logic [1:0]  DATA_BYTES  = 2'h3;
	localparam int          CMD_MSB     = 23;
	localparam int          CMD_LSB     = 20;
	localparam int          CODE_MSB    = 15;
	localparam logic [15:0] ZERO_SCALE  = 16'h0000;
	localparam logic [15:0] MID_SCALE   = 16'h8000;

	typedef enum logic [1:0] {
		PIN_LOW   = 2'h0,
		PIN_FLOAT = 2'h1,
		PIN_HIGH  = 2'h2
	} dws_pin_t;

	typedef enum logic [3:0] {
		CMD_WRITE        = 4'h0,
		CMD_UPDATE       = 4'h1,
		CMD_WRITE_UPDATE = 4'h3,
		CMD_POWER_DOWN   = 4'h4,
		CMD_NOP          = 4'hF
	} dws_cmd_t;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'h0,
		RX_ADDR   = 3'h1,
		RX_ACK    = 3'h2,
		RX_DATA   = 3'h3,
		RX_IGNORE = 3'h4
	} dws_rx_t;

	typedef enum logic [2:0] {
		DET_DRV_LO = 3'h0,
		DET_REL_LO = 3'h1,
		DET_DRV_HI = 3'h2,
		DET_REL_HI = 3'h3,
		DET_DONE   = 3'h4
	} dws_det_t;

	// Register map
	localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
	localparam logic [31:0] REG_STATUS = 32'h0000_0004;
	localparam logic [31:0] REG_INPUT  = 32'h0000_0008;
	localparam logic [31:0] REG_DAC    = 32'h0000_000C;
	localparam logic [31:0] REG_PINS   = 32'h0000_0010;
	localparam logic [1:0]  CTRL_RESET = 2'h3;
	localparam int          CTRL_RX_EN = 0;
	localparam int          CTRL_GL_EN = 1;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : dws_pkg

// ===== dws_addr_detect.sv
`timescale 1ns/1ps

module dws_addr_detect (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Address pins
	input  wire logic [2:0] pin_in,
	output logic      [2:0] pin_out,
	output logic      [2:0] pin_oe,
	// Result
	output logic      [5:0] pin_state,
	output logic            done
);

	logic [2:0]              sync1_q, sync2_q;
	logic [2:0]              low_smp_q, low_smp_d;
	logic [5:0]              state_q, state_d;
	logic [5:0]              state_cand;
	dws_pkg::dws_det_t       st_q, st_d;
	logic [dws_pkg::DET_CNT_W-1:0] cnt_q, cnt_d;
	logic                    drv_q, drv_d;
	logic                    oe_q, oe_d;

	// Floating pin keeps the level last driven; a tied pin ignores it
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_pin
			assign state_cand[2*g+1:2*g] = (low_smp_q[g] != sync2_q[g]) ? dws_pkg::PIN_FLOAT :
				(sync2_q[g] ? dws_pkg::PIN_HIGH : dws_pkg::PIN_LOW);
		end
	endgenerate

	always_comb
	begin
		st_d      = st_q;
		cnt_d     = cnt_q + 1'b1;
		drv_d     = drv_q;
		oe_d      = oe_q;
		low_smp_d = low_smp_q;
		state_d   = state_q;
		case (st_q)
			dws_pkg::DET_DRV_LO:
			begin
				oe_d  = 1'b1;
				drv_d = 1'b0;
				if (cnt_q == dws_pkg::DET_CNT_W'(dws_pkg::PIN_DRIVE_CYC))
				begin
					st_d  = dws_pkg::DET_REL_LO;
					cnt_d = '0;
					oe_d  = 1'b0;
				end
			end
			dws_pkg::DET_REL_LO:
				if (cnt_q == dws_pkg::DET_CNT_W'(dws_pkg::PIN_SETTLE_CYC))
				begin
					low_smp_d = sync2_q;
					st_d      = dws_pkg::DET_DRV_HI;
					cnt_d     = '0;
					oe_d      = 1'b1;
					drv_d     = 1'b1;
				end
			dws_pkg::DET_DRV_HI:
				if (cnt_q == dws_pkg::DET_CNT_W'(dws_pkg::PIN_DRIVE_CYC))
				begin
					st_d  = dws_pkg::DET_REL_HI;
					cnt_d = '0;
					oe_d  = 1'b0;
				end
			dws_pkg::DET_REL_HI:
				if (cnt_q == dws_pkg::DET_CNT_W'(dws_pkg::PIN_SETTLE_CYC))
				begin
					state_d = state_cand;
					st_d    = dws_pkg::DET_DONE;
				end
			dws_pkg::DET_DONE:
				cnt_d = cnt_q;
			default:
				st_d = dws_pkg::DET_DRV_LO;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		sync1_q <= pin_in;
		sync2_q <= sync1_q;
		if (!aresetn)
		begin
			st_q      <= dws_pkg::DET_DRV_LO;
			cnt_q     <= '0;
			drv_q     <= 1'b0;
			oe_q      <= 1'b0;
			low_smp_q <= 3'h0;
			state_q   <= 6'h00;
		end
		else
		begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			drv_q     <= drv_d;
			oe_q      <= oe_d;
			low_smp_q <= low_smp_d;
			state_q   <= state_d;
		end
	end

	assign pin_out   = {3{drv_q}};
	assign pin_oe    = {3{oe_q}};
	assign pin_state = state_q;
	assign done      = (st_q == dws_pkg::DET_DONE);

endmodule : dws_addr_detect

// ===== dws_top.sv
// Function
// - Each address pin is read as low, floating or high.
// - Three ternary pins give twenty-seven distinct slave addresses.
// - Address is ((n/4)+1, 00, n mod 4) with n = 9*p2 + 3*p1 + p0.
// - Fixed global address 1110011 is also accepted.
// - A global write loads every device with the usual three data bytes.
// - Read requests are never acknowledged and return no data.
// - Accepted bytes are acknowledged by holding data low through the ninth clock.
// - Data falling while clock high starts a transaction.
// - Data rising while clock high ends a transaction and frees the bus.
// - Serial data bits are sampled on rising clock edges.
// - Data line is released while shifting, pulled low only for acknowledges.
// - Load falling edge after a complete write copies input register to DAC.
// - Load low without a complete four-byte write does not update the DAC.
// - Power-down command is inhibited while the load input is low.
// - Reset loads zero-scale, or mid-scale in the alternate variant.
// - DAC register is an unsigned binary code driven out as is.
// - Address pins are driven during detection to find floating ones.
// - First data byte holds the command in its upper nibble; two bytes follow.
// - Commands: write, update, write and update, power down, no operation.
// - Bytes after the third data byte are not acknowledged.
// - Input code sits most significant bit first in the data word.
`timescale 1ns/1ps

module dws_top #(
	parameter bit MID_SCALE_RESET = 1'b0
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial bus
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Address select pins
	input  wire logic        addr_sel_pin_0_in,
	output logic             addr_sel_pin_0_out,
	output logic             addr_sel_pin_0_oe,
	input  wire logic        addr_sel_pin_1_in,
	output logic             addr_sel_pin_1_out,
	output logic             addr_sel_pin_1_oe,
	input  wire logic        addr_sel_pin_2_in,
	output logic             addr_sel_pin_2_out,
	output logic             addr_sel_pin_2_oe,
	// Converter side
	input  wire logic        async_load_n,
	output logic [15:0]      dac_code,
	output logic             dac_powered_down
);

	logic [2:0]  pin_out, pin_oe;
	logic [5:0]  pin_state;
	logic        det_done;

	dws_addr_detect u_addr_detect (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_in    ({addr_sel_pin_2_in, addr_sel_pin_1_in, addr_sel_pin_0_in}),
		.pin_out   (pin_out),
		.pin_oe    (pin_oe),
		.pin_state (pin_state),
		.done      (det_done)
	);

	assign addr_sel_pin_0_out = pin_out[0];
	assign addr_sel_pin_1_out = pin_out[1];
	assign addr_sel_pin_2_out = pin_out[2];
	assign addr_sel_pin_0_oe  = pin_oe[0];
	assign addr_sel_pin_1_oe  = pin_oe[1];
	assign addr_sel_pin_2_oe  = pin_oe[2];

	// Own address from pin states
	logic [4:0] pin_index;
	logic [6:0] own_addr_q, own_addr_d;
	logic       own_valid_q, own_valid_d;

	always_comb
	begin
		pin_index = 5'(({3'h0, pin_state[5:4]} * 5'h9) + ({3'h0, pin_state[3:2]} * 5'h3)
			+ {3'h0, pin_state[1:0]});
		own_addr_d  = {3'(pin_index[4:2] + dws_pkg::ADDR_HI_INC), 2'h0, pin_index[1:0]};
		own_valid_d = det_done;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			own_addr_q  <= 7'h00;
			own_valid_q <= 1'b0;
		end
		else
		begin
			own_addr_q  <= own_addr_d;
			own_valid_q <= own_valid_d;
		end
	end

	// Line synchronisers and glitch filter: index 0 clock, 1 data, 2 load
	logic [2:0] sync1_q, sync2_q;
	logic [dws_pkg::FILTER_TAPS-1:0] hist_q [3];
	logic [2:0] filt_q, filt_d, prev_q;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_filt
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					hist_q[g] <= '1;
				else
					hist_q[g] <= {hist_q[g][dws_pkg::FILTER_TAPS-2:0], sync2_q[g]};
			end
			assign filt_d[g] = (&hist_q[g]) ? 1'b1 : ((|hist_q[g]) ? filt_q[g] : 1'b0);
		end
	endgenerate

	always_ff @(posedge aclk)
	begin
		sync1_q <= {async_load_n, sda_in, scl};
		sync2_q <= sync1_q;
		if (!aresetn)
		begin
			filt_q <= 3'h7;
			prev_q <= 3'h7;
		end
		else
		begin
			filt_q <= filt_d;
			prev_q <= filt_q;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det, load_fall, load_low;
	assign scl_rise  = filt_q[0] & ~prev_q[0];
	assign scl_fall  = ~filt_q[0] & prev_q[0];
	assign start_det = filt_q[0] & prev_q[0] & prev_q[1] & ~filt_q[1];
	assign stop_det  = filt_q[0] & prev_q[0] & ~prev_q[1] & filt_q[1];
	assign load_fall = prev_q[2] & ~filt_q[2];
	assign load_low  = ~filt_q[2];

	// Control register bits
	logic [1:0] ctrl_q, ctrl_d;

	// Serial receiver
	dws_pkg::dws_rx_t rx_q, rx_d;
	logic [3:0]  bit_q, bit_d;
	logic [7:0]  shift_q, shift_d;
	logic [1:0]  byte_q, byte_d;
	logic [23:0] word_q, word_d;
	logic        ack_hi_q, ack_hi_d;
	logic        exec_q, exec_d;
	logic        clr_q, clr_d;
	logic        oe_q, oe_d;
	logic        addr_hit;

	always_comb
	begin
		rx_d     = rx_q;
		bit_d    = bit_q;
		shift_d  = shift_q;
		byte_d   = byte_q;
		word_d   = word_q;
		ack_hi_d = ack_hi_q;
		exec_d   = 1'b0;
		clr_d    = 1'b0;
		addr_hit = own_valid_q && ctrl_q[dws_pkg::CTRL_RX_EN] && ((shift_q[7:1] == own_addr_q)
			|| (ctrl_q[dws_pkg::CTRL_GL_EN] && shift_q[7:1] == dws_pkg::GLOBAL_ADDR));
		if (start_det)
		begin
			rx_d   = dws_pkg::RX_ADDR;
			bit_d  = 4'h0;
			byte_d = 2'h0;
		end
		else if (stop_det)
			rx_d = dws_pkg::RX_IDLE;
		else
		begin
			case (rx_q)
				dws_pkg::RX_ADDR, dws_pkg::RX_DATA:
				begin
					if (scl_rise)
					begin
						shift_d = {shift_q[6:0], filt_q[1]};
						bit_d   = bit_q + 4'h1;
					end
					else if (scl_fall && bit_q == dws_pkg::BIT_LAST)
					begin
						bit_d = 4'h0;
						if (rx_q == dws_pkg::RX_ADDR)
						begin
							if (addr_hit && !shift_q[0])
							begin
								rx_d  = dws_pkg::RX_ACK;
								clr_d = 1'b1;
							end
							else
								rx_d = dws_pkg::RX_IGNORE;
						end
						else if (byte_q != dws_pkg::DATA_BYTES)
						begin
							word_d = {word_q[15:0], shift_q};
							byte_d = byte_q + 2'h1;
							rx_d   = dws_pkg::RX_ACK;
						end
						else
							rx_d = dws_pkg::RX_IGNORE;
					end
				end
				dws_pkg::RX_ACK:
				begin
					if (scl_rise)
						ack_hi_d = 1'b1;
					else if (scl_fall && ack_hi_q)
					begin
						ack_hi_d = 1'b0;
						rx_d     = dws_pkg::RX_DATA;
						exec_d   = (byte_q == dws_pkg::DATA_BYTES);
					end
				end
				dws_pkg::RX_IDLE, dws_pkg::RX_IGNORE:
					rx_d = rx_q;
				default:
					rx_d = dws_pkg::RX_IDLE;
			endcase
		end
		if (rx_d != dws_pkg::RX_ACK)
			ack_hi_d = 1'b0;
		oe_d = (rx_d == dws_pkg::RX_ACK);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_q     <= dws_pkg::RX_IDLE;
			bit_q    <= 4'h0;
			shift_q  <= 8'h00;
			byte_q   <= 2'h0;
			word_q   <= 24'h00_0000;
			ack_hi_q <= 1'b0;
			exec_q   <= 1'b0;
			clr_q    <= 1'b0;
			oe_q     <= 1'b0;
		end
		else
		begin
			rx_q     <= rx_d;
			bit_q    <= bit_d;
			shift_q  <= shift_d;
			byte_q   <= byte_d;
			word_q   <= word_d;
			ack_hi_q <= ack_hi_d;
			exec_q   <= exec_d;
			clr_q    <= clr_d;
			oe_q     <= oe_d;
		end
	end

	// Input register, DAC register and power state
	localparam logic [15:0] RESET_CODE = MID_SCALE_RESET ? dws_pkg::MID_SCALE : dws_pkg::ZERO_SCALE;
	logic [15:0] input_q, input_d, dac_q, dac_d;
	logic        pd_q, pd_d, done_q, done_d;
	logic [15:0] rx_code;

	always_comb
	begin
		input_d = input_q;
		dac_d   = dac_q;
		pd_d    = pd_q;
		done_d  = done_q;
		rx_code = word_q[dws_pkg::CODE_MSB:0];
		if (exec_q)
		begin
			done_d = 1'b1;
			case (word_q[dws_pkg::CMD_MSB:dws_pkg::CMD_LSB])
				dws_pkg::CMD_WRITE:
					input_d = rx_code;
				dws_pkg::CMD_UPDATE:
				begin
					dac_d = input_q;
					pd_d  = 1'b0;
				end
				dws_pkg::CMD_WRITE_UPDATE:
				begin
					input_d = rx_code;
					dac_d   = rx_code;
					pd_d    = 1'b0;
				end
				dws_pkg::CMD_POWER_DOWN:
					pd_d = ~load_low;
				default:
					pd_d = pd_q;
			endcase
			if (load_low)
			begin
				dac_d = input_d;
				pd_d  = 1'b0;
			end
		end
		else
		begin
			if (clr_q)
				done_d = 1'b0;
			if (load_fall)
			begin
				pd_d = 1'b0;
				if (done_q)
					dac_d = input_q;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			input_q <= RESET_CODE;
			dac_q   <= RESET_CODE;
			pd_q    <= 1'b0;
			done_q  <= 1'b0;
		end
		else
		begin
			input_q <= input_d;
			dac_q   <= dac_d;
			pd_q    <= pd_d;
			done_q  <= done_d;
		end
	end

	// AXI4-Lite slave
	logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
	logic        wstrb0_q, wstrb0_d;
	logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

	always_comb
	begin
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb0_d  = wstrb0_q;
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		ctrl_d    = ctrl_q;
		if (s_axi_awvalid && awready_q)
		begin
			awaddr_d  = s_axi_awaddr;
			aw_have_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q)
		begin
			wdata_d  = s_axi_wdata;
			wstrb0_d = s_axi_wstrb[0];
			w_have_d = 1'b1;
		end
		if (s_axi_bvalid && s_axi_bready)
			bvalid_d = 1'b0;
		else if (aw_have_q && w_have_q && !bvalid_q)
		begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = dws_pkg::RESP_OKAY;
			case (awaddr_q)
				dws_pkg::REG_CTRL:
					if (wstrb0_q)
						ctrl_d = wdata_q[1:0];
				dws_pkg::REG_STATUS, dws_pkg::REG_INPUT, dws_pkg::REG_DAC, dws_pkg::REG_PINS:
					bresp_d = dws_pkg::RESP_OKAY;
				default:
					bresp_d = dws_pkg::RESP_SLVERR;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready)
			rvalid_d = 1'b0;
		else if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d  = dws_pkg::RESP_OKAY;
			case (s_axi_araddr)
				dws_pkg::REG_CTRL:   rdata_d = {30'h0, ctrl_q};
				dws_pkg::REG_STATUS: rdata_d = {9'h0, own_addr_q, 8'h0, 1'h0, rx_q, 1'h0,
					pd_q, done_q, own_valid_q};
				dws_pkg::REG_INPUT:  rdata_d = {16'h0, input_q};
				dws_pkg::REG_DAC:    rdata_d = {16'h0, dac_q};
				dws_pkg::REG_PINS:   rdata_d = {26'h0, pin_state};
				default:
				begin
					rdata_d = 32'h0000_0000;
					rresp_d = dws_pkg::RESP_SLVERR;
				end
			endcase
		end
		awready_d = ~aw_have_d & ~bvalid_d;
		wready_d  = ~w_have_d & ~bvalid_d;
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_q  <= 32'h0000_0000;
			wdata_q   <= 32'h0000_0000;
			wstrb0_q  <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= dws_pkg::RESP_OKAY;
			rvalid_q  <= 1'b0;
			rresp_q   <= dws_pkg::RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			ctrl_q    <= dws_pkg::CTRL_RESET;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
		end
		else
		begin
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb0_q  <= wstrb0_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
			ctrl_q    <= ctrl_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
		end
	end

	assign s_axi_awready    = awready_q;
	assign s_axi_wready     = wready_q;
	assign s_axi_bvalid     = bvalid_q;
	assign s_axi_bresp      = bresp_q;
	assign s_axi_arready    = arready_q;
	assign s_axi_rvalid     = rvalid_q;
	assign s_axi_rresp      = rresp_q;
	assign s_axi_rdata      = rdata_q;
	assign sda_oe           = oe_q;
	assign sda_out          = 1'b0;
	assign dac_code         = dac_q;
	assign dac_powered_down = pd_q;

endmodule : dws_top

// ===== dws_top_checker.sv
`timescale 1ns/1ps

module dws_top_checker #(
	parameter bit MID_SCALE_RESET = 1'b0
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Pins and converter
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        addr_sel_pin_0_oe,
	input wire logic        async_load_n,
	input wire logic [15:0] dac_code,
	input wire logic        dac_powered_down
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	rst_values_a: assert property (disable iff (1'b0)
		!aresetn |=> !sda_oe && !s_axi_bvalid && !s_axi_rvalid && dac_code ==
		(MID_SCALE_RESET ? dws_pkg::MID_SCALE : dws_pkg::ZERO_SCALE)) else $error("bad reset state");
	ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe[*8])
		else $error("acknowledge too short");
	ack_drain_a: assert property (sda_oe |-> !sda_out)
		else $error("data pin driven high");
	pin_drive_a: assert property ($rose(aresetn) |-> ##[1:20] addr_sel_pin_0_oe)
		else $error("address pin not driven");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response missing");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	pd_inhibit_a: assert property ((!async_load_n)[*8] |-> !$rose(dac_powered_down))
		else $error("power down while load low");
	load_wake_a: assert property ($fell(async_load_n) |-> ##[1:12] !dac_powered_down)
		else $error("load did not power up");
endmodule : dws_top_checker

bind dws_top dws_top_checker #(.MID_SCALE_RESET(MID_SCALE_RESET)) i_dws_top_checker (
	.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pin_0_oe(addr_sel_pin_0_oe),
	.async_load_n(async_load_n), .dac_code(dac_code), .dac_powered_down(dac_powered_down)
);

// ===== dws_master_model.sv
`timescale 1ns/1ps

module dws_master_model (
	// Serial lines
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	task automatic start_c();
		sda_m = 1'b1;
		#40 scl = 1'b1;
		#40 sda_m = 1'b0;
		#80 scl = 1'b0;
	endtask : start_c

	task automatic stop_c();
		#40 sda_m = 1'b0;
		#40 scl = 1'b1;
		#80 sda_m = 1'b1;
		#160;
	endtask : stop_c

	task automatic clk_bit(input logic v, output logic s);
		#40 sda_m = v;
		#40 scl = 1'b1;
		#70 s = sda;
		#10 scl = 1'b0;
	endtask : clk_bit

	// Low phase stretched around the acknowledge so the slave's late release stays clear
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], s);
		#80;
		clk_bit(1'b1, ack);
		#160;
	endtask : send_byte
endmodule : dws_master_model

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
	logic        aclk, aresetn = 1'b0, async_load_n = 1'b1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, m_ctrl, pm [3];
	logic [31:0] s_axi_rdata, d;
	logic        scl, sda_m, sda_out, sda_oe, dac_powered_down, m_pd, m_cmpl;
	logic [15:0] dac_code, m_in, m_dac;
	logic        addr_sel_pin_0_out, addr_sel_pin_1_out, addr_sel_pin_2_out;
	logic        addr_sel_pin_0_oe, addr_sel_pin_1_oe, addr_sel_pin_2_oe;
	logic [2:0]  pv, hold = 3'h0;
	logic [6:0]  own;
	logic [3:0]  cmds [6] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h4, 4'hF};
	int          fail_count = 0, n_tests = 0, n;
	wire         sda_in = sda_m & ~(sda_oe & ~sda_out);
	wire [2:0]   po = {addr_sel_pin_2_out, addr_sel_pin_1_out, addr_sel_pin_0_out};
	wire [2:0]   pe = {addr_sel_pin_2_oe, addr_sel_pin_1_oe, addr_sel_pin_0_oe};
	wire         addr_sel_pin_0_in = pv[0];
	wire         addr_sel_pin_1_in = pv[1];
	wire         addr_sel_pin_2_in = pv[2];

	dws_top i_dws_top (.*);
	dws_master_model i_dws_master_model (.scl(scl), .sda_m(sda_m), .sda(sda_in));

	// Tied pins ignore the drive; a floating pin keeps the last level driven onto it
	always_comb
		for (int i = 0; i < 3; i++)
			pv[i] = (pm[i] == 2'h1) ? (pe[i] ? po[i] : hold[i]) : (pm[i] == 2'h2);
	always @(posedge aclk)
		hold <= pv;

	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		#1_000_000;
		fail_count++;
		report_and_stop();
	end

	// Ready for the answer is raised with the request and held until it is sampled
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic ld_set(input logic v);
		@(posedge aclk);
		async_load_n <= v;
		if (!v && m_cmpl)
			m_dac = m_in;
		if (!v)
			m_pd = 1'b0;
		repeat (20) @(posedge aclk);
		`CHK(dac_code, m_dac)
		`CHK(dac_powered_down, m_pd)
	endtask : ld_set

	task automatic xfer(input logic [7:0] a, input logic [3:0] c, input int nb, input bit cut);
		logic       ak;
		logic       hit;
		logic       s;
		logic [7:0] b [$];
		for (int i = 0; i < nb; i++)
			b.push_back(8'($urandom));
		b[0][7:4] = c;
		hit = m_ctrl[0] && !a[0]
			&& (a[7:1] == own || (m_ctrl[1] && a[7:1] == dws_pkg::GLOBAL_ADDR));
		i_dws_master_model.start_c();
		i_dws_master_model.send_byte(a, ak);
		`CHK(ak, !hit)
		for (int i = 0; i < nb; i++)
			if (cut && i == nb - 1)
				for (int k = 7; k > 3; k--)
					i_dws_master_model.clk_bit(b[i][k], s);
			else
			begin
				i_dws_master_model.send_byte(b[i], ak);
				`CHK(ak, !(hit && i < 3))
			end
		i_dws_master_model.stop_c();
		if (hit)
			m_cmpl = !cut;
		if (hit && !cut && (c == 4'h0 || c == 4'h3))
			m_in = {b[1], b[2]};
		if (hit && !cut && (c == 4'h1 || c == 4'h3 || !async_load_n))
		begin
			m_dac = m_in;
			m_pd = 1'b0;
		end
		if (hit && !cut && c == 4'h4 && async_load_n)
			m_pd = 1'b1;
		repeat (10) @(posedge aclk);
		`CHK(dac_code, m_dac)
		`CHK(dac_powered_down, m_pd)
	endtask : xfer

	initial
	begin
		void'($urandom(32'h973de7ec));
		for (int r = 0; r < 2; r++)
		begin
			for (int i = 0; i < 3; i++)
				pm[i] = 2'($urandom_range(2));
			n = 9 * pm[2] + 3 * pm[1] + pm[0];
			own = {3'(n / 4 + 1), 2'h0, 2'(n % 4)};
			m_dac = dws_pkg::ZERO_SCALE;
			m_in = dws_pkg::ZERO_SCALE;
			m_pd = 1'b0;
			m_cmpl = 1'b0;
			m_ctrl = 2'h3;
			@(posedge aclk);
			aresetn <= 1'b0;
			repeat (6) @(posedge aclk);
			aresetn <= 1'b1;
			repeat (200) @(posedge aclk);
			`CHK(dac_code, m_dac)
			axi_rd(dws_pkg::REG_STATUS, d, rs);
			`CHK({d[22:16], d[0]}, {own, 1'b1})
			axi_rd(dws_pkg::REG_PINS, d, rs);
			`CHK(d[5:0], {pm[2], pm[1], pm[0]})
			ld_set(1'b0);
			ld_set(1'b1);
			$display("address pins done");
			for (int k = 0; k < 6; k++)
				xfer({own, 1'b0}, cmds[k], (k == 2) ? 4 : 3, 1'b0);
			$display("commands done");
			xfer({own, 1'b0}, 4'h0, 3, 1'b0);
			ld_set(1'b0);
			xfer({own, 1'b0}, 4'h4, 3, 1'b0);
			ld_set(1'b1);
			$display("load input done");
			xfer({dws_pkg::GLOBAL_ADDR, 1'b0}, 4'h3, 3, 1'b0);
			xfer({own, 1'b1}, 4'h3, 3, 1'b0);
			xfer({own ^ 7'h04, 1'b0}, 4'h3, 3, 1'b0);
			// Input now differs from the DAC, so a wrongly honoured load would show
			xfer({own, 1'b0}, 4'h0, 3, 1'b0);
			xfer({own, 1'b0}, 4'h3, 3, 1'b1);
			ld_set(1'b0);
			ld_set(1'b1);
			$display("addressing and abort done");
			axi_wr(dws_pkg::REG_CTRL, 32'h0000_0002, rs);
			m_ctrl = 2'h2;
			xfer({own, 1'b0}, 4'h3, 3, 1'b0);
			axi_wr(dws_pkg::REG_CTRL, 32'h0000_0001, rs);
			m_ctrl = 2'h1;
			axi_rd(dws_pkg::REG_CTRL, d, rs);
			`CHK(d, {30'h0, m_ctrl})
			xfer({dws_pkg::GLOBAL_ADDR, 1'b0}, 4'h3, 3, 1'b0);
			axi_wr(dws_pkg::REG_CTRL, 32'h0000_0003, rs);
			m_ctrl = 2'h3;
			axi_wr(32'h0000_0040, $urandom, rs);
			`CHK(rs, dws_pkg::RESP_SLVERR)
			axi_rd(32'h0000_0040, d, rs);
			`CHK({rs, d}, {dws_pkg::RESP_SLVERR, 32'h0000_0000})
			axi_rd(dws_pkg::REG_DAC, d, rs);
			`CHK({rs, d[15:0]}, {dws_pkg::RESP_OKAY, m_dac})
			$display("registers done");
		end
		report_and_stop();
	end
endmodule : tb_top
